// [hdl/cfe_pkg.sv]
// shared constants for the capture frame event and shadowing block
package cfe_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SYNC     = 8'h04;
  localparam logic [7:0] OFF_LINE_IRQ = 8'h08;
  localparam logic [7:0] OFF_MEM_BASE = 8'h0C;
  localparam logic [7:0] OFF_WINDOW   = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_ACTIVE   = 8'h18;
  localparam logic [7:0] OFF_MEM_ACT  = 8'h1C;
  localparam logic [7:0] OFF_OPT      = 8'h20;
  // field positions
  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_BUSY     = 1;
  localparam int SYNC_IRQ_EN   = 0;
  localparam int SYNC_VPOL     = 1;
  localparam int SYNC_LATCH    = 2;
  localparam int SYNC_SWAP     = 3;
  localparam int SYNC_OUTMODE  = 4;
  localparam int STAT_FP_LATE  = 0;
  localparam int ACT_ENABLE    = 0;
  localparam int ACT_SWAP      = 1;
  localparam int ACT_IRQ_EN    = 2;
  localparam int CNT_W         = 16;
  // reset values
  localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
  localparam logic [31:0] RST_SYNC     = 32'h0000_0000;
  localparam logic [31:0] RST_LINE_IRQ = 32'h0000_0000;
  localparam logic [31:0] RST_MEM_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_WINDOW   = 32'h0000_0000;
  localparam logic [31:0] RST_OPT      = 32'h0000_0000;
  localparam logic [15:0] RST_CNT      = 16'h0000;
  // frame state, one-hot
  typedef enum logic [1:0] {
    FS_IDLE = 2'b01,
    FS_BUSY = 2'b10
  } cfe_frame_t;
endpackage

// [hdl/cfe_sync.sv]
// two flip-flop synchroniser for pins from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module cfe_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins and synchronised levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// [hdl/cfe_line_irq.sv]
// counts horizontal sync edges from frame start and pulses once at target
`timescale 1ns/1ps
`default_nettype none
module cfe_line_irq (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // frame events
  input  wire logic        sof,
  input  wire logic        hs_edge,
  input  wire logic [15:0] target,
  input  wire logic        irq_en,
  // event pulse
  output logic             irq
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        irq_nxt;
  logic [15:0] cnt_inc;

  always_comb begin
    cnt_inc  = cnt_r + 16'h0001;
    cnt_nxt  = cnt_r;
    done_nxt = done_r;
    irq_nxt  = 1'b0;
    if (sof) begin
      cnt_nxt  = cfe_pkg::RST_CNT;
      done_nxt = 1'b0;
    end else if (hs_edge && !done_r) begin
      cnt_nxt = cnt_inc;
      if (cnt_inc == target) begin
        done_nxt = 1'b1;
        irq_nxt  = irq_en;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= cfe_pkg::RST_CNT;
      done_r <= 1'b1;
      irq    <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
      irq    <= irq_nxt;
    end
  end
endmodule
`default_nettype wire

// [hdl/cfe_top.sv]
// capture controller frame events, status flags and register shadowing
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// R1 - all interrupts gated by sync interrupt enable
// R2 - interrupts continue while controller disabled
// R3 - line interrupts fire at programmed sync count
// R4 - polarity picks rising or falling frame edge
// R5 - each field's vertical sync restarts counting
// R6 - strobe falling edge raises third interrupt
// R7 - busy set at enabled frame start, cleared after
// R8 - late fault pixel flag, write one clears
// R9 - shadowed fields read back last written value
// R10 - enable takes effect at next frame start
// R11 - base latched at frame or window start
// R12 - swap applied only in vertical active period
// R13 - plain fields take effect immediately
// R14 - optional group shadowed unless latch mode set
// R15 - software sets latch mode before use
// R16 - changes before frame end apply next frame
// R17 - pixel clock at most 90 MHz
// R18 - base and offset on 32-byte boundaries
// R19 - no write gate with formatter path
// R20 - port width and height limits
// R21 - luma chroma mode clears listed features
// R22 - raw mode leaves resizer path off
// R23 - fault table on 64-byte boundary
// R24 - runs continuously, finishes frame on disable
// R25 - sync output mode starts on enable
// R26 - one pulse per event after synchronisation
module cfe_top (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // sensor pins
  input  wire logic        pixel_clk,
  input  wire logic        vertical_sync,
  input  wire logic        horizontal_sync,
  input  wire logic        write_strobe,
  // fetch path event
  input  wire logic        fault_pixel_late,
  // interrupt pulses
  output logic             line_count_irq_a,
  output logic             line_count_irq_b,
  output logic             write_strobe_irq,
  // active settings
  output logic             enable_act,
  output logic             busy,
  output logic             luma_chroma_swap_act,
  output logic [31:0]      memory_output_base_act,
  output logic [31:0]      opt_cfg_act,
  output logic [31:0]      window_act,
  output logic [31:0]      line_irq_cfg
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronised pins and edges
  logic [3:0]         pin_q;
  logic               pix_q;
  logic               vs_q;
  logic               hs_q;
  logic               ws_q;
  logic               pix_d_r;
  logic               vs_r;
  logic               hs_r;
  logic               ws_d_r;
  logic               vs_nxt;
  logic               hs_nxt;
  logic               pix_rise;
  logic               sof;
  logic               hs_edge;
  logic               vs_active;
  logic               ws_fall;

  cfe_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({write_strobe, horizontal_sync, vertical_sync, pixel_clk}),
    .q       (pin_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // software copies, active copies and counters
  logic [31:0]        ctrl_r;
  logic [31:0]        ctrl_nxt;
  logic [31:0]        sync_r;
  logic [31:0]        sync_nxt;
  logic [31:0]        line_r;
  logic [31:0]        line_nxt;
  logic [31:0]        base_r;
  logic [31:0]        base_nxt;
  logic [31:0]        win_r;
  logic [31:0]        win_nxt;
  logic [31:0]        opt_r;
  logic [31:0]        opt_nxt;
  logic               fp_late_r;
  logic               fp_late_nxt;
  logic               en_act_nxt;
  logic               swap_act_nxt;
  logic               irq_en_act_r;
  logic               irq_en_act_nxt;
  logic [31:0]        base_act_nxt;
  logic [31:0]        opt_act_nxt;
  logic [31:0]        win_act_nxt;
  logic [15:0]        pix_cnt_r;
  logic [15:0]        pix_cnt_nxt;
  logic [15:0]        ln_cnt_r;
  logic [15:0]        ln_cnt_nxt;
  logic               win_hit;
  logic               wr_ok;
  logic               rd_setup;
  logic [31:0]        prdata_nxt;
  logic               pslverr_nxt;
  logic               vpol;
  logic               latch_mode;
  cfe_pkg::cfe_frame_t fs_r;
  cfe_pkg::cfe_frame_t fs_nxt;

  // known register offsets
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == cfe_pkg::OFF_CTRL)     || (a == cfe_pkg::OFF_SYNC)    ||
             (a == cfe_pkg::OFF_LINE_IRQ) || (a == cfe_pkg::OFF_MEM_BASE)||
             (a == cfe_pkg::OFF_WINDOW)   || (a == cfe_pkg::OFF_STATUS)  ||
             (a == cfe_pkg::OFF_ACTIVE)   || (a == cfe_pkg::OFF_MEM_ACT) ||
             (a == cfe_pkg::OFF_OPT);
  endfunction

  function automatic logic wr_hit(input logic ok, input logic [7:0] a,
                                  input logic [7:0] off);
    wr_hit = ok && (a == off);
  endfunction

  assign pix_q      = pin_q[0];
  assign vs_q       = pin_q[1];
  assign hs_q       = pin_q[2];
  assign ws_q       = pin_q[3];
  assign vpol       = sync_r[cfe_pkg::SYNC_VPOL];
  assign latch_mode = sync_r[cfe_pkg::SYNC_LATCH];
  assign pready     = 1'b1;
  assign busy       = (fs_r == cfe_pkg::FS_BUSY);
  assign line_irq_cfg = line_r;
  assign wr_ok      = psel && penable && pwrite;
  assign rd_setup   = psel && !penable;

  ////////////////////////////////////////////////////////////////////////////
  // sensor timing: sample syncs on pixel clock rising edges
  always_comb begin
    pix_rise = pix_q && !pix_d_r;
    vs_nxt   = pix_rise ? vs_q : vs_r;
    hs_nxt   = pix_rise ? hs_q : hs_r;
    // R4 polarity edge
    sof      = pix_rise && (vpol ? (vs_r && !vs_q) : (!vs_r && vs_q));
    hs_edge  = pix_rise && hs_q && !hs_r;
    vs_active = vpol ? !vs_r : vs_r;
    // R6 strobe falling edge
    ws_fall  = ws_d_r && !ws_q;
    // pixel and line position within each field
    pix_cnt_nxt = pix_cnt_r;
    ln_cnt_nxt  = ln_cnt_r;
    if (sof) begin
      pix_cnt_nxt = cfe_pkg::RST_CNT;
      ln_cnt_nxt  = cfe_pkg::RST_CNT;
    end else if (hs_edge) begin
      pix_cnt_nxt = cfe_pkg::RST_CNT;
      ln_cnt_nxt  = ln_cnt_r + 16'h0001;
    end else if (pix_rise) begin
      pix_cnt_nxt = pix_cnt_r + 16'h0001;
    end
    win_hit = pix_rise && !hs_edge && !sof &&
              (pix_cnt_r == win_act_nxt[15:0]) &&
              (ln_cnt_r == win_act_nxt[31:16]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // line count interrupts, one counter each
  // R3 R5 line count pulses
  cfe_line_irq u_line_a (
    .pclk    (pclk),
    .presetn (presetn),
    .sof     (sof),
    .hs_edge (hs_edge),
    .target  (line_r[15:0]),
    .irq_en  (irq_en_act_r),
    .irq     (line_count_irq_a)
  );

  cfe_line_irq u_line_b (
    .pclk    (pclk),
    .presetn (presetn),
    .sof     (sof),
    .hs_edge (hs_edge),
    .target  (line_r[31:16]),
    .irq_en  (irq_en_act_r),
    .irq     (line_count_irq_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register writes, shadow transfers and frame state
  always_comb begin
    ctrl_nxt = ctrl_r;
    sync_nxt = sync_r;
    line_nxt = line_r;
    base_nxt = base_r;
    win_nxt  = win_r;
    opt_nxt  = opt_r;
    if (wr_hit(wr_ok, paddr, cfe_pkg::OFF_CTRL)) begin
      ctrl_nxt = {31'h0, pwdata[cfe_pkg::CTRL_ENABLE]};
    end
    if (wr_hit(wr_ok, paddr, cfe_pkg::OFF_SYNC)) begin
      sync_nxt = {27'h0, pwdata[4:0]};
    end
    // R13 line_irq_cfg follows writes at once; base, window and opt are shadowed copies
    if (wr_hit(wr_ok, paddr, cfe_pkg::OFF_LINE_IRQ)) begin
      line_nxt = pwdata;
    end
    if (wr_hit(wr_ok, paddr, cfe_pkg::OFF_MEM_BASE)) begin
      base_nxt = pwdata;
    end
    if (wr_hit(wr_ok, paddr, cfe_pkg::OFF_WINDOW)) begin
      win_nxt = pwdata;
    end
    if (wr_hit(wr_ok, paddr, cfe_pkg::OFF_OPT)) begin
      opt_nxt = pwdata;
    end
    // R8 late flag, the set wins over the clear
    fp_late_nxt = fp_late_r;
    if (wr_hit(wr_ok, paddr, cfe_pkg::OFF_STATUS) &&
        pwdata[cfe_pkg::STAT_FP_LATE]) begin
      fp_late_nxt = 1'b0;
    end
    if (fault_pixel_late) begin
      fp_late_nxt = 1'b1;
    end
    // R10 R16 enable loads at frame start
    en_act_nxt = enable_act;
    if (sof) begin
      en_act_nxt = ctrl_r[cfe_pkg::CTRL_ENABLE];
    end
    // R25 sync output mode starts at once
    if (sync_r[cfe_pkg::SYNC_OUTMODE] && !busy &&
        ctrl_r[cfe_pkg::CTRL_ENABLE]) begin
      en_act_nxt = 1'b1;
    end
    // R7 R24 busy from an enabled frame start, or at once in sync output mode, until a frame start with enable cleared
    fs_nxt = fs_r;
    case (fs_r)
      cfe_pkg::FS_IDLE: begin
        if ((sof || sync_r[cfe_pkg::SYNC_OUTMODE]) &&
            ctrl_r[cfe_pkg::CTRL_ENABLE]) begin
          fs_nxt = cfe_pkg::FS_BUSY;
        end
      end
      cfe_pkg::FS_BUSY: begin
        if (sof && !ctrl_r[cfe_pkg::CTRL_ENABLE]) begin
          fs_nxt = cfe_pkg::FS_IDLE;
        end
      end
      default: fs_nxt = cfe_pkg::FS_IDLE;
    endcase
    // R12 swap only in active vertical period
    swap_act_nxt = luma_chroma_swap_act;
    if (vs_active) begin
      swap_act_nxt = sync_r[cfe_pkg::SYNC_SWAP];
    end
    // R14 optional group shadowed unless latch mode set
    irq_en_act_nxt = irq_en_act_r;
    opt_act_nxt    = opt_cfg_act;
    win_act_nxt    = window_act;
    if (latch_mode || sof) begin
      irq_en_act_nxt = sync_r[cfe_pkg::SYNC_IRQ_EN];
      opt_act_nxt    = opt_r;
      win_act_nxt    = win_r;
    end
    // R11 base latch point
    base_act_nxt = memory_output_base_act;
    if (latch_mode ? win_hit : sof) begin
      base_act_nxt = base_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase
  always_comb begin
    prdata_nxt  = prdata;
    pslverr_nxt = 1'b0;
    if (rd_setup) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        // R9 written registers read back their stored bits (CTRL bit 0 only, SYNC bits 4:0), with busy added in CTRL
        cfe_pkg::OFF_CTRL: begin
          prdata_nxt = ctrl_r;
          prdata_nxt[cfe_pkg::CTRL_BUSY] = busy;
        end
        cfe_pkg::OFF_SYNC:     prdata_nxt = sync_r;
        cfe_pkg::OFF_LINE_IRQ: prdata_nxt = line_r;
        cfe_pkg::OFF_MEM_BASE: prdata_nxt = base_r;
        cfe_pkg::OFF_WINDOW:   prdata_nxt = win_r;
        cfe_pkg::OFF_STATUS: begin
          prdata_nxt[cfe_pkg::STAT_FP_LATE] = fp_late_r;
        end
        cfe_pkg::OFF_ACTIVE: begin
          prdata_nxt[cfe_pkg::ACT_ENABLE] = enable_act;
          prdata_nxt[cfe_pkg::ACT_SWAP]   = luma_chroma_swap_act;
          prdata_nxt[cfe_pkg::ACT_IRQ_EN] = irq_en_act_r;
        end
        cfe_pkg::OFF_MEM_ACT:  prdata_nxt = memory_output_base_act;
        cfe_pkg::OFF_OPT:      prdata_nxt = opt_r;
        default:               prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (psel && penable && !mapped(paddr)) begin
      pslverr_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_d_r                <= 1'b0;
      vs_r                   <= 1'b0;
      hs_r                   <= 1'b0;
      ws_d_r                 <= 1'b0;
      pix_cnt_r              <= cfe_pkg::RST_CNT;
      ln_cnt_r               <= cfe_pkg::RST_CNT;
      ctrl_r                 <= cfe_pkg::RST_CTRL;
      sync_r                 <= cfe_pkg::RST_SYNC;
      line_r                 <= cfe_pkg::RST_LINE_IRQ;
      base_r                 <= cfe_pkg::RST_MEM_BASE;
      win_r                  <= cfe_pkg::RST_WINDOW;
      opt_r                  <= cfe_pkg::RST_OPT;
      fp_late_r              <= 1'b0;
      enable_act             <= 1'b0;
      fs_r                   <= cfe_pkg::FS_IDLE;
      luma_chroma_swap_act   <= 1'b0;
      irq_en_act_r           <= 1'b0;
      opt_cfg_act            <= cfe_pkg::RST_OPT;
      window_act             <= cfe_pkg::RST_WINDOW;
      memory_output_base_act <= cfe_pkg::RST_MEM_BASE;
      write_strobe_irq       <= 1'b0;
      prdata                 <= 32'h0000_0000;
    end else begin
      pix_d_r                <= pix_q;
      vs_r                   <= vs_nxt;
      hs_r                   <= hs_nxt;
      ws_d_r                 <= ws_q;
      pix_cnt_r              <= pix_cnt_nxt;
      ln_cnt_r               <= ln_cnt_nxt;
      ctrl_r                 <= ctrl_nxt;
      sync_r                 <= sync_nxt;
      line_r                 <= line_nxt;
      base_r                 <= base_nxt;
      win_r                  <= win_nxt;
      opt_r                  <= opt_nxt;
      fp_late_r              <= fp_late_nxt;
      enable_act             <= en_act_nxt;
      fs_r                   <= fs_nxt;
      luma_chroma_swap_act   <= swap_act_nxt;
      irq_en_act_r           <= irq_en_act_nxt;
      opt_cfg_act            <= opt_act_nxt;
      window_act             <= win_act_nxt;
      memory_output_base_act <= base_act_nxt;
      // R1 R2 R26 strobe pulse, gated only by irq enable
      write_strobe_irq       <= ws_fall && irq_en_act_r;
      prdata                 <= prdata_nxt;
    end
  end

  // error answer is combinational with the access phase
  assign pslverr = pslverr_nxt;
endmodule
`default_nettype wire

// [bench/cfe_sensor.sv]
// sensor model driving pixel clock, sync pins and write strobe
`timescale 1ns/1ps
`default_nettype none
module cfe_sensor (
  // sensor pins
  output logic pixel_clk,
  output logic vertical_sync,
  output logic horizontal_sync,
  output logic write_strobe
);
  initial begin
    pixel_clk = 1'b0;
    vertical_sync = 1'b0;
    horizontal_sync = 1'b0;
    write_strobe = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) begin
      #100 pixel_clk = 1'b1;
      #100 pixel_clk = 1'b0;
    end
  endtask
  task automatic hline();
    horizontal_sync = 1'b1;
    tick(2);
    horizontal_sync = 1'b0;
    tick(4);
  endtask
  // clock stands still outside frames; two blanking lines follow
  task automatic frame(input logic pol, input int n);
    vertical_sync = pol;
    tick(2);
    vertical_sync = ~pol;
    tick(2);
    repeat (n) hline();
    vertical_sync = pol;
    repeat (2) hline();
    tick(2);
  endtask
  task automatic strobe();
    write_strobe = 1'b0;
    #400 write_strobe = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// [bench/cfe_chk.sv]
// port-level assertions for the capture frame event block
`timescale 1ns/1ps
`default_nettype none
module cfe_chk (
  // clock, reset, apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // pins and outputs
  input wire logic        write_strobe,
  input wire logic        line_count_irq_a,
  input wire logic        line_count_irq_b,
  input wire logic        write_strobe_irq,
  input wire logic        enable_act,
  input wire logic        busy,
  input wire logic [31:0] line_irq_cfg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic irq_en_r;
  logic irq_en_nxt;
  logic wr_sync;
  assign wr_sync = psel && penable && pwrite
                   && (paddr == cfe_pkg::OFF_SYNC);
  always_comb begin
    irq_en_nxt = wr_sync ? pwdata[cfe_pkg::SYNC_IRQ_EN] : irq_en_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= 1'b0;
    end else begin
      irq_en_r <= irq_en_nxt;
    end
  end
  property p_gate;
    (line_count_irq_a || line_count_irq_b || write_strobe_irq) |-> irq_en_r;
  endproperty
  a_gate: assert property (p_gate) else $error("irq while off");
  property p_pa;
    line_count_irq_a |=> !line_count_irq_a;
  endproperty
  a_pa: assert property (p_pa) else $error("irq a too long");
  property p_pw;
    write_strobe_irq |=> !write_strobe_irq;
  endproperty
  a_pw: assert property (p_pw) else $error("strobe irq too long");
  property p_ws;
    write_strobe_irq |-> !write_strobe && $past(!write_strobe, 2);
  endproperty
  a_ws: assert property (p_ws) else $error("strobe irq no fall");
  property p_br;
    $rose(busy) |-> enable_act;
  endproperty
  a_br: assert property (p_br) else $error("busy while off");
  property p_bf;
    $fell(busy) |-> !enable_act;
  endproperty
  a_bf: assert property (p_bf) else $error("busy ended early");
  property p_en;
    $changed(enable_act) |-> $changed(busy);
  endproperty
  a_en: assert property (p_en) else $error("enable off frame");
  property p_cfg;
    (psel && penable && pwrite && paddr == cfe_pkg::OFF_LINE_IRQ)
      |=> line_irq_cfg == $past(pwdata);
  endproperty
  a_cfg: assert property (p_cfg) else $error("targets late");
endmodule
bind cfe_top cfe_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .write_strobe(write_strobe), .line_count_irq_a(line_count_irq_a),
  .line_count_irq_b(line_count_irq_b), .write_strobe_irq(write_strobe_irq),
  .enable_act(enable_act), .busy(busy), .line_irq_cfg(line_irq_cfg));
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the capture frame event block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, flate, pol;
  logic        perr, serr;
  logic [31:0] win_act;
  logic        pxc, vs, hs, ws, irq_a, irq_b, irq_w, en_act, busy, swp;
  logic [7:0]  paddr;
  logic [15:0] tga, tgb;
  logic [31:0] pwdata, prdata, base_act, opt_act, lcfg, rv, opt, base, nb;
  int          err_count, n_compared, cnt_a, cnt_b, cnt_w;
  cfe_sensor sen_u (.pixel_clk(pxc), .vertical_sync(vs),
    .horizontal_sync(hs), .write_strobe(ws));
  cfe_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(perr), .prdata(prdata), .pixel_clk(pxc),
    .vertical_sync(vs), .horizontal_sync(hs), .write_strobe(ws),
    .fault_pixel_late(flate), .line_count_irq_a(irq_a),
    .line_count_irq_b(irq_b), .write_strobe_irq(irq_w),
    .enable_act(en_act), .busy(busy), .luma_chroma_swap_act(swp),
    .memory_output_base_act(base_act), .opt_cfg_act(opt_act),
    .window_act(win_act), .line_irq_cfg(lcfg));
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (irq_a === 1'b1) cnt_a++;
    if (irq_b === 1'b1) cnt_b++;
    if (irq_w === 1'b1) cnt_w++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    serr = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic frm(input logic p, input int n);
    sen_u.frame(p, n);
    repeat (8) @(posedge pclk);
  endtask
  function automatic int hits(input logic [15:0] t);
    return (t != 16'h0 && t <= 16'h6) ? 1 : 0;
  endfunction
  initial begin
    #1000000;
    err_count++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, flate, paddr, pwdata} = '0;
    {err_count, n_compared, cnt_a, cnt_b, cnt_w} = '0;
    void'($urandom(10880));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(cfe_pkg::OFF_CTRL, 32'h0);
    chk(32'(serr), 32'h0);
    rdc(8'h3C, 32'h0);
    chk(32'(serr), 32'h1);
    opt = $urandom();
    base = $urandom() & 32'hFFFF_FFE0;
    apb(1'b1, cfe_pkg::OFF_OPT, opt);
    apb(1'b1, cfe_pkg::OFF_MEM_BASE, base);
    apb(1'b1, cfe_pkg::OFF_LINE_IRQ, 32'h0006_0003);
    apb(1'b1, cfe_pkg::OFF_SYNC, 32'h1);
    apb(1'b1, cfe_pkg::OFF_CTRL, 32'h1);
    rdc(cfe_pkg::OFF_CTRL, 32'h1);
    rdc(cfe_pkg::OFF_OPT, opt);
    chk({en_act, base_act[0]} & 2'b10, 32'h0);
    chk(opt_act, 32'h0);
    chk(base_act, 32'h0);
    cnt_a = 0;
    frm(1'b0, 4);
    chk(32'({busy, en_act}), 32'h3);
    chk(opt_act, opt);
    chk(base_act, base);
    chk(32'(cnt_a), 32'h1);
    apb(1'b1, cfe_pkg::OFF_CTRL, 32'h0);
    chk(32'(busy), 32'h1);
    cnt_a = 0;
    cnt_b = 0;
    frm(1'b0, 4);
    chk(32'({busy, en_act}), 32'h0);
    chk(32'(cnt_a + cnt_b), 32'h2);
    $display("frame shadow test done");
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      apb(1'b1, cfe_pkg::OFF_SYNC, {28'h0, 2'b01, pol, 1'b1});
      for (int k = 0; k < 3; k++) begin
        tga = (k == 0) ? 16'h6 : (k == 1) ? 16'h0 : 16'($urandom() % 8);
        tgb = 16'($urandom() % 7 + 1);
        apb(1'b1, cfe_pkg::OFF_LINE_IRQ, {tgb, tga});
        @(posedge pclk);
        chk(lcfg, {tgb, tga});
        cnt_a = 0;
        cnt_b = 0;
        frm(pol, 4);
        frm(pol, 4);
        chk(32'(cnt_a), 32'(2 * hits(tga)));
        chk(32'(cnt_b), 32'(2 * hits(tgb)));
      end
    end
    $display("line count test done");
    opt = $urandom();
    apb(1'b1, cfe_pkg::OFF_OPT, opt);
    repeat (2) @(posedge pclk);
    chk(opt_act, opt);
    nb = $urandom() & 32'hFFFF_FFE0;
    apb(1'b1, cfe_pkg::OFF_WINDOW, 32'h0009_0001);
    apb(1'b1, cfe_pkg::OFF_MEM_BASE, nb);
    chk(win_act, 32'h0009_0001);
    frm(pol, 4);
    chk(base_act, base);
    apb(1'b1, cfe_pkg::OFF_WINDOW, 32'h0002_0001);
    frm(pol, 4);
    chk(base_act, nb);
    rdc(cfe_pkg::OFF_MEM_ACT, nb);
    apb(1'b1, cfe_pkg::OFF_SYNC, {28'h0, 2'b11, pol, 1'b1});
    repeat (8) @(posedge pclk);
    chk(32'(swp), 32'h0);
    frm(pol, 1);
    chk(32'(swp), 32'h1);
    $display("latch test done");
    cnt_w = 0;
    sen_u.strobe();
    chk(32'(cnt_w), 32'h1);
    apb(1'b1, cfe_pkg::OFF_SYNC, {28'h0, 2'b11, pol, 1'b0});
    repeat (4) @(posedge pclk);
    {cnt_a, cnt_b, cnt_w} = '0;
    sen_u.strobe();
    frm(pol, 4);
    chk(32'(cnt_a + cnt_b + cnt_w), 32'h0);
    $display("irq gate test done");
    flate <= 1'b1;
    @(posedge pclk);
    flate <= 1'b0;
    rdc(cfe_pkg::OFF_STATUS, 32'h1);
    apb(1'b1, cfe_pkg::OFF_STATUS, 32'h0);
    rdc(cfe_pkg::OFF_STATUS, 32'h1);
    apb(1'b1, cfe_pkg::OFF_STATUS, 32'h1);
    rdc(cfe_pkg::OFF_STATUS, 32'h0);
    $display("fault flag test done");
    apb(1'b1, cfe_pkg::OFF_SYNC, {27'h0, 1'b1, 2'b01, pol, 1'b1});
    apb(1'b1, cfe_pkg::OFF_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'({busy, en_act}), 32'h3);
    rdc(cfe_pkg::OFF_ACTIVE, 32'h7);
    $display("output mode test done");
    stop_test();
  end
endmodule
`default_nettype wire
